// >>> rtl/tpg_pkg.sv
// package of the link test-pattern generator: offsets, fields, reset values, codes
// assumes a byte-wide register port with word addresses as printed
package tpg_pkg;
   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam logic [15:0] TPG_UPAT_BASE = 16'h0551;
   localparam logic [15:0] TPG_UPAT_LAST = 16'h0558;
   localparam logic [15:0] TPG_SYNC_CTRL = 16'h0572;
   localparam logic [15:0] TPG_IF_CTRL = 16'h0573;
   localparam logic [15:0] TPG_LL_CTRL = 16'h0574;
   localparam logic [15:0] TPG_STATUS = 16'h0575;
   // --------------------------------------------------------------
   // fields and reset values
   // --------------------------------------------------------------
   localparam int TPG_CODE_LSB = 0;
   localparam int TPG_INJ_LSB = 4;
   localparam int TPG_LL_LSB = 0;
   localparam logic [7:0] TPG_SYNC_DIS = 8'hC0;
   localparam logic [7:0] TPG_RST_BYTE = 8'h00;
   localparam logic [30:0] TPG_SEED31 = 31'h0003AFFF;
   localparam logic [22:0] TPG_SEED23 = 23'h003AFF;
   localparam logic [14:0] TPG_SEED15 = 15'h03AF;
   localparam logic [8:0] TPG_SEED9 = 9'h092;
   localparam logic [6:0] TPG_SEED7 = 7'h07;
   localparam logic [15:0] TPG_CHK_A = 16'h5555;
   localparam logic [15:0] TPG_CHK_B = 16'hAAAA;
   localparam int TPG_BUF_DEPTH = 2;
   // --------------------------------------------------------------
   // test codes and injection points
   // --------------------------------------------------------------
   typedef enum logic [3:0] {
      TPG_OFF = 4'h0, TPG_CHECK = 4'h1, TPG_TOGGLE = 4'h2, TPG_PN31 = 4'h3,
      TPG_PN23 = 4'h4, TPG_PN15 = 4'h5, TPG_PN9 = 4'h6, TPG_PN7 = 4'h7,
      TPG_RAMP = 4'h8, TPG_UREP = 4'hE, TPG_USGL = 4'hF
   } tpg_code_e;
   typedef enum logic [1:0] {
      TPG_INJ_SAMPLE = 2'h0, TPG_INJ_PHY10 = 2'h1, TPG_INJ_SCR8 = 2'h2
   } tpg_inj_e;
endpackage : tpg_pkg

// >>> rtl/tpg_gen.sv
// link test-pattern generator with register port and two-entry output buffer
// assumes one frame/character clock; the receiver may stall through out_ready
//
// Contract
// - link-layer test from low three bits
// - codes off, checkerboard, word toggle
// - code 0011 PN31 seed 0x0003AFFF
// - code 0100 PN23 seed 0x003AFF
// - codes 0101-0111 PN15, PN9, PN7
// - ramp wraps at injection width
// - user patterns one to four repeat
// - user patterns once, then zeros
// - point 00: 16-bit, once per frame
// - point 01: 10-bit, upper user bits
// - point 10: 8-bit, upper user bits
// - code bits 3:0, point bits 5:4
`timescale 1ns/1ps
`default_nettype none
module tpg_gen
   import tpg_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic unit_tick,
   input wire logic [15:0] norm_data,
   output logic [15:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic in_ready,
   output logic test_active,
   output logic [2:0] ll_test_sel,
   output logic sync_in_disable
);
   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [7:0][7:0] upat;
      logic [7:0] sync_ctrl;
      logic [7:0] if_ctrl;
      logic [7:0] ll_ctrl;
      logic [7:0] rdata;
      logic [30:0] pn31;
      logic [22:0] pn23;
      logic [14:0] pn15;
      logic [8:0] pn9;
      logic [6:0] pn7;
      logic [15:0] ramp;
      logic phase;
      logic [1:0] uidx;
      logic udone;
      logic [1:0][15:0] buf_d;
      logic [1:0] cnt;
      logic rd_ptr;
      logic wr_ptr;
   } tpg_state_s;

   tpg_state_s st_r, st_nxt;
   logic [3:0] code;
   logic [1:0] inj;
   logic [15:0] word;
   logic [15:0] uword;
   logic [15:0] cut_word;
   logic push;
   logic pop;
   logic restart;

   assign code = st_r.if_ctrl[TPG_CODE_LSB +: 4];
   assign inj = st_r.if_ctrl[TPG_INJ_LSB +: 2];
   assign ll_test_sel = st_r.ll_ctrl[TPG_LL_LSB +: 3];
   assign sync_in_disable = (st_r.sync_ctrl == TPG_SYNC_DIS);
   assign test_active = (code != TPG_OFF);
   assign reg_rdata = st_r.rdata;
   assign in_ready = (st_r.cnt != 2'(TPG_BUF_DEPTH));
   assign out_valid = (st_r.cnt != 2'd0);
   assign out_data = st_r.buf_d[st_r.rd_ptr];
   assign push = unit_tick && in_ready;
   assign pop = out_valid && out_ready;
   assign uword = {st_r.upat[{st_r.uidx, 1'b1}], st_r.upat[{st_r.uidx, 1'b0}]};

   // --------------------------------------------------------------
   // pattern word before width cut
   // --------------------------------------------------------------
   always_comb begin
      word = norm_data;
      unique case (code)
         TPG_CHECK: word = st_r.phase ? TPG_CHK_B : TPG_CHK_A;
         TPG_TOGGLE: word = {16{st_r.phase}};
         TPG_PN31: word = st_r.pn31[30:15];
         TPG_PN23: word = st_r.pn23[22:7];
         TPG_PN15: word = {st_r.pn15, 1'b0};
         TPG_PN9: word = {st_r.pn9, 7'h00};
         TPG_PN7: word = {st_r.pn7, 9'h000};
         TPG_RAMP: begin
            // ramp lives in the low bits, shifted up to the cut point
            unique case (inj)
               TPG_INJ_PHY10: word = {st_r.ramp[9:0], 6'h00};
               TPG_INJ_SCR8: word = {st_r.ramp[7:0], 8'h00};
               default: word = st_r.ramp;
            endcase
         end
         TPG_UREP: word = uword;
         TPG_USGL: word = st_r.udone ? 16'h0000 : uword;
         default: word = (code == TPG_OFF) ? norm_data : 16'h0000;
      endcase
   end

   // --------------------------------------------------------------
   // width cut at the injection point
   // --------------------------------------------------------------
   always_comb begin
      cut_word = word;
      if (code != TPG_OFF) begin
         unique case (inj)
            TPG_INJ_PHY10: cut_word = word & 16'hFFC0;
            TPG_INJ_SCR8: cut_word = word & 16'hFF00;
            default: cut_word = word;
         endcase
      end
   end

   // --------------------------------------------------------------
   // registers, sequence advance, buffer
   // --------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      restart = 1'b0;
      if (reg_rd) begin
         st_nxt.rdata = TPG_RST_BYTE;
         if (reg_addr >= TPG_UPAT_BASE && reg_addr <= TPG_UPAT_LAST) begin
            st_nxt.rdata = st_r.upat[3'(reg_addr - TPG_UPAT_BASE)];
         end else if (reg_addr == TPG_SYNC_CTRL) begin
            st_nxt.rdata = st_r.sync_ctrl;
         end else if (reg_addr == TPG_IF_CTRL) begin
            st_nxt.rdata = st_r.if_ctrl;
         end else if (reg_addr == TPG_LL_CTRL) begin
            st_nxt.rdata = st_r.ll_ctrl;
         end else if (reg_addr == TPG_STATUS) begin
            st_nxt.rdata = {3'h0, st_r.udone, st_r.uidx, st_r.cnt};
         end
      end
      if (reg_wr) begin
         if (reg_addr >= TPG_UPAT_BASE && reg_addr <= TPG_UPAT_LAST) begin
            st_nxt.upat[3'(reg_addr - TPG_UPAT_BASE)] = reg_wdata;
         end else if (reg_addr == TPG_SYNC_CTRL) begin
            st_nxt.sync_ctrl = reg_wdata;
         end else if (reg_addr == TPG_IF_CTRL) begin
            st_nxt.if_ctrl = {2'h0, reg_wdata[5:0]};
            restart = (reg_wdata[3:0] != code) || (reg_wdata[5:4] != inj);
         end else if (reg_addr == TPG_LL_CTRL) begin
            st_nxt.ll_ctrl = {5'h00, reg_wdata[2:0]};
         end
      end
      if (restart) begin
         st_nxt.pn31 = TPG_SEED31;
         st_nxt.pn23 = TPG_SEED23;
         st_nxt.pn15 = TPG_SEED15;
         st_nxt.pn9 = TPG_SEED9;
         st_nxt.pn7 = TPG_SEED7;
         st_nxt.ramp = 16'h0000;
         st_nxt.phase = 1'b0;
         st_nxt.uidx = 2'd0;
         st_nxt.udone = 1'b0;
      end else if (push) begin
         // one step per frame, symbol or octet as the tick marks
         st_nxt.pn31 = {st_r.pn31[29:0], st_r.pn31[30] ^ st_r.pn31[27]};
         st_nxt.pn23 = {st_r.pn23[21:0], st_r.pn23[22] ^ st_r.pn23[17]};
         st_nxt.pn15 = {st_r.pn15[13:0], st_r.pn15[14] ^ st_r.pn15[13]};
         st_nxt.pn9 = {st_r.pn9[7:0], st_r.pn9[8] ^ st_r.pn9[4]};
         st_nxt.pn7 = {st_r.pn7[5:0], st_r.pn7[6] ^ st_r.pn7[5]};
         st_nxt.ramp = st_r.ramp + 16'h0001;
         st_nxt.phase = ~st_r.phase;
         st_nxt.uidx = st_r.uidx + 2'd1;
         if (st_r.uidx == 2'd3) begin
            st_nxt.udone = 1'b1;
         end
      end
      if (push) begin
         st_nxt.buf_d[st_r.wr_ptr] = cut_word;
         st_nxt.wr_ptr = ~st_r.wr_ptr;
      end
      if (pop) begin
         st_nxt.rd_ptr = ~st_r.rd_ptr;
      end
      st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
      if (soft_rst) begin
         st_nxt.if_ctrl = TPG_RST_BYTE;
         st_nxt.ll_ctrl = TPG_RST_BYTE;
         st_nxt.sync_ctrl = TPG_RST_BYTE;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.pn31 <= TPG_SEED31;
         st_r.pn23 <= TPG_SEED23;
         st_r.pn15 <= TPG_SEED15;
         st_r.pn9 <= TPG_SEED9;
         st_r.pn7 <= TPG_SEED7;
      end else begin
         st_r <= st_nxt;
      end
   end

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   sequence s_code_write(logic [3:0] c);
      reg_wr && !soft_rst && reg_addr == TPG_IF_CTRL && reg_wdata[3:0] == c;
   endsequence

   a_ll_sel_field: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !soft_rst && reg_addr == TPG_LL_CTRL |=> ll_test_sel == $past(reg_wdata[2:0]))
      else $error("link test select not taken");
   a_chk_alt: assert property (@(posedge clock) disable iff (sys_rst)
      code == TPG_CHECK && push && !reg_wr && !soft_rst |=> st_r.phase != $past(st_r.phase))
      else $error("checkerboard phase stuck");
   a_pn31_seed: assert property (@(posedge clock) disable iff (sys_rst)
      s_code_write(4'h3) ##0 code != 4'h3 |=> st_r.pn31 == TPG_SEED31)
      else $error("pn31 seed wrong");
   a_pn23_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.pn23[0] == ($past(st_r.pn23[22]) ^ $past(st_r.pn23[17])))
      else $error("pn23 feedback wrong");
   a_pn7_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.pn7[0] == ($past(st_r.pn7[6]) ^ $past(st_r.pn7[5])))
      else $error("pn7 feedback wrong");
   a_ramp_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.ramp == $past(st_r.ramp) + 16'h0001)
      else $error("ramp did not advance");
   a_user_zero: assert property (@(posedge clock) disable iff (sys_rst)
      code == TPG_USGL && st_r.udone && push && !reg_wr |=> out_valid ##0
      st_r.buf_d[$past(st_r.wr_ptr)] == 16'h0000)
      else $error("single user mode not zero");
   a_new_restart: assert property (@(posedge clock) disable iff (sys_rst)
      s_code_write(4'hE) ##0 code != 4'hE |=> st_r.uidx == 2'd0 && !st_r.udone)
      else $error("user sequence did not restart");
   a_soft_normal: assert property (@(posedge clock) disable iff (sys_rst)
      soft_rst |=> !test_active && ll_test_sel == 3'h0 && !sync_in_disable)
      else $error("soft reset left test mode");
   a_buf_bound: assert property (@(posedge clock) disable iff (sys_rst)
      st_r.cnt == 2'd2 && !pop |=> st_r.cnt == 2'd2 ##0 !in_ready)
      else $error("buffer overfilled");

   // --------------------------------------------------------------
   // sequence steps, restarts, width cuts, dropped ticks and register fields
   // --------------------------------------------------------------
   sequence s_push_in(logic [3:0] c);
      push && !reg_wr && !soft_rst && code == c;
   endsequence

   a_pn31_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.pn31[0] == ($past(st_r.pn31[30]) ^ $past(st_r.pn31[27])))
      else $error("pn31 feedback wrong");
   a_pn15_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.pn15[0] == ($past(st_r.pn15[14]) ^ $past(st_r.pn15[13])))
      else $error("pn15 feedback wrong");
   a_pn9_step: assert property (@(posedge clock) disable iff (sys_rst)
      push && !reg_wr |=> st_r.pn9[0] == ($past(st_r.pn9[8]) ^ $past(st_r.pn9[4])))
      else $error("pn9 feedback wrong");
   a_chk_first: assert property (@(posedge clock) disable iff (sys_rst)
      s_code_write(4'h1) ##0 code != 4'h1 |=> !st_r.phase)
      else $error("checkerboard did not start at first word");
   a_urep_wrap: assert property (@(posedge clock) disable iff (sys_rst)
      s_push_in(4'hE) ##0 st_r.uidx == 2'd3 |=> st_r.uidx == 2'd0)
      else $error("user repeat did not wrap");
   a_off_pass: assert property (@(posedge clock) disable iff (sys_rst)
      s_push_in(4'h0) |=> st_r.buf_d[$past(st_r.wr_ptr)] == $past(norm_data))
      else $error("normal data not passed");
   a_phy_cut: assert property (@(posedge clock) disable iff (sys_rst)
      push && code != TPG_OFF && inj == TPG_INJ_PHY10 |=> st_r.buf_d[$past(st_r.wr_ptr)][5:0] == 6'h00)
      else $error("symbol word not cut to ten bits");
   a_scr_cut: assert property (@(posedge clock) disable iff (sys_rst)
      push && code != TPG_OFF && inj == TPG_INJ_SCR8 |=> st_r.buf_d[$past(st_r.wr_ptr)][7:0] == 8'h00)
      else $error("octet word not cut to eight bits");
   a_if_field: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !soft_rst && reg_addr == TPG_IF_CTRL |=> code == $past(reg_wdata[3:0]) && inj == $past(reg_wdata[5:4]))
      else $error("interface test fields not taken");
   a_pn7_restart: assert property (@(posedge clock) disable iff (sys_rst)
      s_code_write(4'h7) ##0 code != 4'h7 |=> st_r.pn7 == TPG_SEED7)
      else $error("pn7 did not restart from seed");
   a_tick_dropped: assert property (@(posedge clock) disable iff (sys_rst)
      unit_tick && !in_ready && !reg_wr |=> st_r.ramp == $past(st_r.ramp))
      else $error("sequence advanced on a dropped tick");
   a_sync_flag: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !soft_rst && reg_addr == TPG_SYNC_CTRL && reg_wdata == TPG_SYNC_DIS |=> sync_in_disable)
      else $error("sync disable flag not raised");
   a_user_first: assert property (@(posedge clock) disable iff (sys_rst)
      s_code_write(4'hF) ##0 code != 4'hF |=> st_r.uidx == 2'd0 && !st_r.udone)
      else $error("single user mode did not restart");
endmodule : tpg_gen
`default_nettype wire

// >>> bench/tpg_rx_model.sv
// receiver model: takes buffered words from the generator, stalls on request
// assumes valid/ready handshake sampled on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tpg_rx_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic out_valid,
   input wire logic [15:0] out_data,
   output logic out_ready
);
   logic [15:0] words[$];
   // ready follows the stall request one cycle later
   always @(posedge clock) begin
      if (sys_rst) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) begin
            words.push_back(out_data);
         end
      end
   end
endmodule : tpg_rx_model
`default_nettype wire

// >>> bench/serial_link_test_pattern_gen_tb_top.sv
// testbench of the link test-pattern generator: register calls, word checks
// assumes the receiver model drains the output buffer unless told to stall
`timescale 1ns/1ps
`default_nettype none
module serial_link_test_pattern_gen_tb_top import tpg_pkg::*;;
   logic clock = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic unit_tick = 1'b0, stall = 1'b0;
   logic [15:0] reg_addr = 16'h0000, norm_data = 16'h1234, out_data, w;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
   logic out_valid, out_ready, in_ready, test_active, sync_in_disable;
   logic [2:0] ll_test_sel;
   logic [15:0] pn[3];
   logic [15:0] pseed[5] = '{TPG_SEED31[30:15], TPG_SEED23[22:7], {TPG_SEED15, 1'b0},
      {TPG_SEED9, 7'h00}, {TPG_SEED7, 9'h000}};
   logic [15:0] up[4] = '{16'h2211, 16'h4433, 16'h6655, 16'h8877};
   logic [7:0] tv[6] = '{8'h01, 8'h02, 8'h11, 8'h12, 8'h21, 8'h22};
   logic [15:0] ta[6] = '{16'h5555, 16'h0000, 16'h5540, 16'h0000, 16'h5500, 16'h0000};
   logic [15:0] tm[6] = '{16'hFFFF, 16'hFFFF, 16'hFFC0, 16'hFFC0, 16'hFF00, 16'hFF00};
   int fails = 0;
   int checked = 0;
   always #5 clock = ~clock;
   tpg_gen uut (.clock, .sys_rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .unit_tick, .norm_data, .out_data, .out_valid, .out_ready, .in_ready,
      .test_active, .ll_test_sel, .sync_in_disable);
   tpg_rx_model rx (.clock, .sys_rst, .stall, .out_valid, .out_data, .out_ready);
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chkw(input logic [15:0] e);
      w = (rx.words.size() > 0) ? rx.words.pop_front() : 16'hXXXX;
      chk(w, e);
   endtask : chkw
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         unit_tick <= 1'b1;
      end
      @(posedge clock);
      unit_tick <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : tick
   task automatic final_report;
      $display("checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      #100_000;
      fails++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rd(TPG_IF_CTRL, d);
      chk(16'(d), 16'h0000);
      rd(16'h0600, d);
      chk(16'(d), 16'h0000);
      tick(1);
      chkw(16'h1234);
      wr(TPG_LL_CTRL, 8'hFF);
      wr(TPG_SYNC_CTRL, TPG_SYNC_DIS);
      rd(TPG_LL_CTRL, d);
      chk(16'(d), 16'h0007);
      chk(16'(ll_test_sel), 16'h0007);
      chk(16'(sync_in_disable), 16'h0001);
      for (int i = 0; i < 6; i++) begin
         wr(TPG_IF_CTRL, tv[i]);
         tick(2);
         chkw(ta[i]);
         chkw(~ta[i] & tm[i]);
      end
      chk(16'(test_active), 16'h0001);
      for (int k = 0; k < 8; k++) begin
         wr(TPG_UPAT_BASE + 16'(k), 8'(17 * (k + 1)));
      end
      rd(TPG_UPAT_LAST, d);
      chk(16'(d), 16'h0088);
      wr(TPG_IF_CTRL, 8'h0E);
      tick(5);
      for (int i = 0; i < 5; i++)
         chkw(up[i % 4]);
      wr(TPG_IF_CTRL, 8'h0F);
      tick(6);
      for (int i = 0; i < 6; i++)
         chkw(i < 4 ? up[i] : 16'h0000);
      wr(TPG_IF_CTRL, 8'h1E);
      tick(1);
      chkw(up[0] & 16'hFFC0);
      wr(TPG_IF_CTRL, 8'h28);
      tick(257);
      for (int i = 0; i < 257; i++)
         chkw({8'(i), 8'h00});
      wr(TPG_IF_CTRL, 8'h08);
      stall <= 1'b1;
      tick(4);
      chk(16'(in_ready), 16'h0000);
      stall <= 1'b0;
      repeat (3) @(posedge clock);
      tick(2);
      for (int i = 0; i < 4; i++)
         chkw(16'(i));
      for (int c = 3; c < 8; c++) begin
         wr(TPG_IF_CTRL, 8'(c));
         tick(3);
         for (int i = 0; i < 3; i++)
            pn[i] = rx.words.pop_front();
         chk(16'(pn[0] !== pn[1]), 16'h0001);
         chk(pn[0], pseed[c - 3]);
         wr(TPG_IF_CTRL, 8'h08);
         wr(TPG_IF_CTRL, 8'(c));
         tick(3);
         for (int i = 0; i < 3; i++)
            chkw(pn[i]);
      end
      wr(TPG_IF_CTRL, 8'hFF);
      rd(TPG_IF_CTRL, d);
      chk(16'(d), 16'h003F);
      @(posedge clock);
      soft_rst <= 1'b1;
      @(posedge clock);
      soft_rst <= 1'b0;
      rd(TPG_IF_CTRL, d);
      chk(16'(d), 16'h0000);
      chk(16'(sync_in_disable), 16'h0000);
      tick(1);
      chkw(16'h1234);
      final_report();
   end
endmodule : serial_link_test_pattern_gen_tb_top
`default_nettype wire
